// ---- common/fcst_defines.vh ----
// constants for the flash control and safety timer block
`ifndef FCST_DEFINES_VH
`define FCST_DEFINES_VH

// =====================================================
// timing
`define FCST_CLK_HZ 50000000
`define FCST_SAFE_MS 1000
`define FCST_PWM_HZ 20000
`define FCST_TICK_HZ 1000
`define FCST_PWM_STEPS 256

// =====================================================
// current code fields
`define FCST_RED_MSB 5
`define FCST_RED_LSB 4
`define FCST_GRN_MSB 3
`define FCST_GRN_LSB 2
`define FCST_BLU_MSB 1
`define FCST_BLU_LSB 0
`define FCST_CODE_FULL 2'h3
`define FCST_MAXCUR_RST 6'h00

`endif

// ---- rtl/fcst_divider.v ----
// one-cycle enable pulse divider
`timescale 1ns/1ps
`default_nettype none

module fcst_divider #(
  parameter DIV = 50000,
  parameter W = 16
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // enable pulse
  output reg tick
);

  reg [W-1:0] cnt_r;

  always @(posedge clk) begin
    if (reset) begin
      cnt_r <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_r == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
      cnt_r <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/fcst_flash_ctrl.v ----
// flash control and safety timer for the three paralleled colour sinks
// Behaviour
// - paralleled sinks add each output's quarter-step share; zero via switch bit
// - in flash mode, trigger high forces full current on following outputs
// - flash pulse end shuts following outputs down, no pre-flash return
// - new pulse refused until flash mode bit written low then high
// - each colour has own safety enable; only those are cut
// - flash mode low: counter runs with any enable; current access restarts it
// - flash mode low: one second reached cuts safe outputs, sets tripped flag
// - flash mode high: counter runs only while trigger is high
// - a cut output resumes when its safety enable is cleared
// - after trip, current access no longer clears; only all enables low
// - internal colour pwm runs at nominal 20 khz from the clock
// - current codes red 5:4, green 3:2, blue 1:0; 25 to 100 percent
// - trigger input is active high
// - switch bit lights its output when block enabled, pwm off and, for a pin-following output outside flash mode, trigger high
`timescale 1ns/1ps
`default_nettype none
`include "fcst_defines.vh"

module fcst_flash_ctrl #(
  parameter SAFE_TICKS = `FCST_SAFE_MS,
  parameter TICK_DIV = `FCST_CLK_HZ / `FCST_TICK_HZ,
  parameter PWM_DIV = `FCST_CLK_HZ / `FCST_PWM_HZ
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // control bits
  input wire block_enable,
  input wire internal_pwm,
  input wire sink_or_switch_select,
  input wire flash_mode,
  input wire trigger_pin_enable,
  input wire red_output_on,
  input wire green_output_on,
  input wire blue_output_on,
  input wire red_follows_trigger,
  input wire green_follows_trigger,
  input wire blue_follows_trigger,
  input wire [2:0] safety_enable,
  input wire [7:0] pwm_duty,
  // maximum-current register
  input wire [5:0] max_current_code,
  input wire max_current_access,
  // trigger pin
  input wire trigger_in,
  // sink outputs and current
  output reg red_sink_output,
  output reg green_sink_output,
  output reg blue_sink_output,
  output reg [1:0] red_current_code,
  output reg [1:0] green_current_code,
  output reg [1:0] blue_current_code,
  output reg [3:0] total_quarters,
  output reg pwm_phase,
  // status
  output reg safety_tripped,
  output reg flash_armed
);

  // =====================================================
  // time bases
  wire ms_tick;
  wire pwm_tick;

  fcst_divider #(.DIV(TICK_DIV), .W(16)) u_ms_div (
    .clk(clk),
    .reset(reset),
    .tick(ms_tick)
  );

  // pwm step at 20 khz times 256
  fcst_divider #(
    .DIV(PWM_DIV / `FCST_PWM_STEPS < 1 ? 1 : PWM_DIV / `FCST_PWM_STEPS),
    .W(16)
  ) u_pwm_div (
    .clk(clk),
    .reset(reset),
    .tick(pwm_tick)
  );

  reg [7:0] pwm_cnt_r;

  always @(posedge clk) begin
    if (reset) begin
      pwm_cnt_r <= 8'h00;
    end else if (pwm_tick) begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end
  end

  // =====================================================
  // flash arming
  reg mode_d_r;
  reg trig_d_r;
  reg pulse_r;
  wire trig_ext = trigger_pin_enable & trigger_in;

  always @(posedge clk) begin
    if (reset) begin
      mode_d_r <= 1'b0;
      trig_d_r <= 1'b0;
      flash_armed <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      mode_d_r <= flash_mode;
      trig_d_r <= trig_ext;
      // rearm only on rising mode bit
      if (flash_mode & ~mode_d_r) begin
        flash_armed <= 1'b1;
      end else if (~flash_mode) begin
        flash_armed <= 1'b0;
      end else if (pulse_r & ~trig_ext) begin
        flash_armed <= 1'b0;
      end
      if (~flash_mode) begin
        pulse_r <= 1'b0;
      end else if (trig_ext & ~trig_d_r & flash_armed) begin
        pulse_r <= 1'b1;
      end else if (~trig_ext) begin
        pulse_r <= 1'b0;
      end
    end
  end

  // =====================================================
  // safety counter
  reg [15:0] safe_cnt_r;
  wire any_safe = |safety_enable;
  wire run = flash_mode ? (trig_ext & any_safe) : any_safe;

  always @(posedge clk) begin
    if (reset) begin
      safe_cnt_r <= 16'h0000;
      safety_tripped <= 1'b0;
    end else if (~any_safe) begin
      safe_cnt_r <= 16'h0000;
      safety_tripped <= 1'b0;
    end else if (safety_tripped) begin
      safe_cnt_r <= safe_cnt_r;
    end else if (~flash_mode & max_current_access) begin
      safe_cnt_r <= 16'h0000;
    end else if (flash_mode & trig_ext & ~trig_d_r) begin
      // each pulse timed alone
      // short pulses must not add up to a trip
      safe_cnt_r <= 16'h0000;
    end else if (run & ms_tick) begin
      if (safe_cnt_r == SAFE_TICKS[15:0] - 16'h0001) begin
        safety_tripped <= 1'b1;
      end
      safe_cnt_r <= safe_cnt_r + 16'h0001;
    end
  end

  // =====================================================
  // output steering
  reg [2:0] on_nxt;
  reg [5:0] code_nxt;
  reg [3:0] sum_nxt;
  reg [2:0] sw;
  reg [2:0] fol;
  reg [2:0] cut;
  reg pwm_on;
  integer i;

  always @* begin
    sw = {red_output_on, green_output_on, blue_output_on};
    fol = {red_follows_trigger, green_follows_trigger, blue_follows_trigger};
    // cut only while enabled and tripped
    cut = safety_enable & {3{safety_tripped}};
    code_nxt = {max_current_code[`FCST_RED_MSB:`FCST_RED_LSB],
      max_current_code[`FCST_GRN_MSB:`FCST_GRN_LSB],
      max_current_code[`FCST_BLU_MSB:`FCST_BLU_LSB]};
    pwm_on = internal_pwm ? (pwm_cnt_r < pwm_duty) : 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      if (!block_enable) begin
        on_nxt[i] = 1'b0;
      end else if (flash_mode & fol[i]) begin
        // full current in pulse, off after
        on_nxt[i] = pulse_r;
        if (pulse_r) begin
          code_nxt[2*i+1 -: 2] = `FCST_CODE_FULL;
        end
      end else if (trigger_pin_enable & fol[i]) begin
        on_nxt[i] = sw[i] & trig_ext & pwm_on;
      end else begin
        on_nxt[i] = sw[i] & pwm_on;
      end
      on_nxt[i] = on_nxt[i] & ~cut[i];
    end
    sum_nxt = 4'h0;
    for (i = 0; i < 3; i = i + 1) begin
      if (on_nxt[i] & ~sink_or_switch_select) begin
        sum_nxt = sum_nxt + {2'b00, code_nxt[2*i+1 -: 2]} + 4'h1;
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      red_sink_output <= 1'b0;
      green_sink_output <= 1'b0;
      blue_sink_output <= 1'b0;
      red_current_code <= 2'h0;
      green_current_code <= 2'h0;
      blue_current_code <= 2'h0;
      total_quarters <= 4'h0;
      pwm_phase <= 1'b0;
    end else begin
      red_sink_output <= on_nxt[2];
      green_sink_output <= on_nxt[1];
      blue_sink_output <= on_nxt[0];
      red_current_code <= code_nxt[5:4];
      green_current_code <= code_nxt[3:2];
      blue_current_code <= code_nxt[1:0];
      total_quarters <= sum_nxt;
      pwm_phase <= pwm_on;
    end
  end

endmodule

`default_nettype wire

// ---- sim/fcst_checker_properties.sv ----
// assertion checker for the flash control block
`timescale 1ns/1ps
`default_nettype none
module fcst_checker (
  // clock, reset and observed ports
  input wire logic clk, reset, flash_mode, trigger_pin_enable, trigger_in,
  input wire logic sink_or_switch_select, red_follows_trigger, red_sink_output,
  input wire logic safety_tripped, flash_armed,
  input wire logic [2:0] safety_enable,
  input wire logic [1:0] red_current_code,
  input wire logic [3:0] total_quarters
);
  // ====================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_reset_clears: assert property (disable iff (1'b0)
    reset |=> !safety_tripped && !flash_armed && total_quarters == 4'h0) else $error("reset");
  a_trip_released: assert property (
    (safety_enable == 3'h0) [*2] |-> !safety_tripped) else $error("trip kept");
  a_trip_cuts_red: assert property (
    (safety_tripped && safety_enable[2]) [*3] |-> !red_sink_output) else $error("red on");
  a_switch_no_quarters: assert property (
    sink_or_switch_select [*2] |-> total_quarters == 4'h0) else $error("quarters");
  a_flash_full_code: assert property (
    (flash_mode && trigger_in && red_follows_trigger && trigger_pin_enable && flash_armed
    && !safety_tripped) [*4] |-> red_current_code == 2'h3) else $error("code");
  a_pulse_end_off: assert property (
    flash_mode && red_follows_trigger && trigger_pin_enable && $past(flash_armed)
    && $fell(trigger_in) |-> ##3 !red_sink_output) else $error("not off");
  a_refuse_repulse: assert property (
    (flash_mode && !flash_armed && red_follows_trigger && trigger_pin_enable) [*3]
    |-> !red_sink_output) else $error("refused");
  a_arm_on_rise: assert property (
    $rose(flash_mode) && !trigger_in |-> ##[1:2] flash_armed) else $error("arm");
endmodule
bind fcst_flash_ctrl fcst_checker u_chk (.*);
`default_nettype wire

// ---- sim/fcst_trigger_src.sv ----
// trigger pin source model
`timescale 1ns/1ps
`default_nettype none
module fcst_trigger_src (
  // clock and command
  input wire logic clk,
  input wire logic fire,
  // trigger pin, driven low between pulses
  output var logic trigger_in
);
  initial trigger_in = 1'b0;
  always @(posedge clk) trigger_in <= #2 fire;
endmodule
`default_nettype wire

// ---- sim/flash_control_safety_timer_bench.sv ----
// self-checking bench for the flash control block
`timescale 1ns/1ps
`default_nettype none
module flash_control_safety_timer_bench;
  // ====================
  // signals
  logic clk = 0, reset = 1, block_enable = 1, internal_pwm = 0, sink_or_switch_select = 0;
  logic flash_mode = 0, trigger_pin_enable = 1, red_output_on = 0, green_output_on = 0;
  logic blue_output_on = 0, red_follows_trigger = 0, green_follows_trigger = 0;
  logic blue_follows_trigger = 0, max_current_access = 0, fire = 0;
  logic [2:0] safety_enable = 0;
  logic [7:0] pwm_duty = 0;
  logic [5:0] max_current_code = 0;
  wire trigger_in, red_sink_output, green_sink_output, blue_sink_output, pwm_phase;
  wire safety_tripped, flash_armed;
  wire [1:0] red_current_code, green_current_code, blue_current_code;
  wire [3:0] total_quarters;
  int fails = 0, samples_checked = 0, cyc = 0;
  // short counts keep the run brief
  fcst_flash_ctrl #(.SAFE_TICKS(4), .TICK_DIV(10)) uut (.*);
  fcst_trigger_src src (.clk(clk), .fire(fire), .trigger_in(trigger_in));
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cyc > 2000) begin
    fails++;
    conclude();
  end
  // ====================
  // helpers and model
  task chk(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  function automatic int quarters();
    int q = 0;
    if (sink_or_switch_select) return 0;
    if (red_output_on) q += max_current_code[5:4] + 1;
    if (green_output_on) q += max_current_code[3:2] + 1;
    if (blue_output_on) q += max_current_code[1:0] + 1;
    return q;
  endfunction
  task conclude();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ====================
  // scenarios
  initial begin
    void'($urandom(39239));
    step(8);
    reset = 0;
    step(1);
    chk({safety_tripped, flash_armed, total_quarters}, 6'h00);
    for (int i = 0; i < 12; i++) begin
      max_current_code = $urandom;
      {red_output_on, green_output_on, blue_output_on} = $urandom;
      sink_or_switch_select = $urandom;
      pwm_duty = $urandom;
      step(3);
      chk({red_sink_output, green_sink_output, blue_sink_output},
          {red_output_on, green_output_on, blue_output_on});
      chk(total_quarters, 6'(quarters()));
      chk(red_current_code, max_current_code[5:4]);
      chk({green_current_code, blue_current_code}, max_current_code[3:0]);
      chk(pwm_phase, 1);
    end
    {sink_or_switch_select, max_current_code} = 0;
    {red_output_on, green_output_on, blue_output_on, red_follows_trigger} = 4'hf;
    flash_mode = 1;
    step(3);
    chk(flash_armed, 1);
    fire = 1;
    step(5);
    chk({red_sink_output, red_current_code, green_current_code}, 5'h1c);
    fire = 0;
    step(5);
    chk({red_sink_output, green_sink_output}, 2'h1);
    fire = 1;
    step(5);
    chk(red_sink_output, 0);
    fire = 0;
    flash_mode = 0;
    step(2);
    flash_mode = 1;
    step(3);
    fire = 1;
    safety_enable = 3'h4;
    step(5);
    chk(red_current_code, 3);
    step(60);
    chk({safety_tripped, red_sink_output}, 2'h2);
    safety_enable = 0;
    step(3);
    chk({safety_tripped, red_sink_output}, 2'h1);
    fire = 0;
    step(5);
    // two short pulses must not add up
    safety_enable = 3'h4;
    repeat (2) begin
      fire = 1;
      step(30);
      fire = 0;
      step(5);
    end
    chk(safety_tripped, 0);
    flash_mode = 0;
    // red back under its switch bit, not the pin
    red_follows_trigger = 0;
    safety_enable = 3'h3;
    repeat (6) begin
      max_current_access = 1;
      step(1);
      max_current_access = 0;
      step(19);
    end
    chk(safety_tripped, 0);
    step(60);
    chk({safety_tripped, red_sink_output, green_sink_output, blue_sink_output}, 4'hc);
    max_current_access = 1;
    step(1);
    max_current_access = 0;
    step(2);
    chk(safety_tripped, 1);
    safety_enable = 0;
    step(3);
    chk({safety_tripped, red_sink_output, green_sink_output, blue_sink_output}, 4'h7);
    internal_pwm = 1;
    pwm_duty = 0;
    step(3);
    chk({pwm_phase, red_sink_output, green_sink_output, blue_sink_output}, 4'h0);
    internal_pwm = 0;
    block_enable = 0;
    step(3);
    chk({pwm_phase, red_sink_output, green_sink_output, blue_sink_output}, 4'h8);
    conclude();
  end
endmodule
`default_nettype wire
